//--- rtl/mwo_pkg.sv
// Purpose: Shared constants and types for the muting with override block
// Assumes: 125 MHz system clock, registers on a 32-bit classic Wishbone slave
// Notes: All configured times are held in milliseconds or seconds
package mwo_pkg;
  // Register byte offsets
  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_TMO = 8'h04;
  localparam logic [7:0] ADR_WIN = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0C;
  // Configuration field positions
  localparam int CFG_TTYPE = 0;
  localparam int CFG_EN_USED = 1;
  localparam int CFG_EN_ONLY = 2;
  localparam int CFG_DIR_LO = 3;
  localparam int CFG_CLOSE_SENS = 5;
  localparam int CFG_BLIND_EN = 6;
  localparam int CFG_OV_MAINT = 7;
  localparam int CFG_RST_MON = 8;
  localparam int CFG_OVOUT_EN = 9;
  localparam int CFG_REQ_EN = 10;
  localparam int CFG_W = 11;
  // Reset values: sequential, always enabled, both directions, 10 s timeouts
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] TMO_RST = 32'h000A_000A;
  localparam logic [31:0] WIN_RST = 32'h00FA_07D0;
  // Direction codes
  localparam logic [1:0] DIR_BOTH = 2'h0;
  localparam logic [1:0] DIR_UP = 2'h1;
  localparam logic [1:0] DIR_DOWN = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYC = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] MS_PER_S = 32'h0000_03E8;
  localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
  // Muting sequence states
  typedef enum logic [3:0] {
    MS_IDLE = 4'b0001,
    MS_FIRST = 4'b0010,
    MS_ACTIVE = 4'b0100,
    MS_BLIND = 4'b1000
  } mwo_mstate_t;
  // Override states
  typedef enum logic [1:0] {
    OV_IDLE = 2'b01,
    OV_ACTIVE = 2'b10
  } mwo_ostate_t;
endpackage

//--- rtl/mwo_top.sv
// Purpose: Safety muting function with attached override function
// Assumes: Pins are asynchronous and pass two flip-flops; one 125 MHz clock
// Notes: Overview of operation follows
// Overview of operation
// RULE1: Muting cycle longer than configured timeout is aborted at once; zero is unlimited. The code does not apply the timeout in the blind state.
// RULE2: Without the enable option muting counts as always enabled.
// RULE3: Enable/disable mode starts a cycle only after a rising enable edge.
// RULE4: Enable/disable mode aborts muting on a falling enable edge in any state.
// RULE5: Enable-only mode never stops a cycle; enable must drop before rearming.
// RULE6: Direction limits sensor order: both ways, one to four, or four to one.
// RULE7: Curtain close ends on curtain rising; sensor close on third sensor clearing.
// RULE8: Curtain close with blind time keeps the curtain seen high after close.
// RULE9: T-type muting activates when both sensors occupy within the window.
// RULE10: T-type muting ends when either of its two sensors releases.
// RULE11: T-type cycle starts only with both sensors low and curtain high.
// RULE12: The two first sensors must activate within the configured sensor time.
// RULE13: Override starts only with muting output low and something occupied.
// RULE14: Override ends when everything is clear or its timeout expires.
// RULE15: Maintained override needs the request held; re-raising allows another.
// RULE16: Pulsed override starts on one request edge; restart needs a new edge.
// RULE17: Override timeout is configurable, zero meaning infinite, and ends override.
// RULE18: Optional active-high output shows override active.
// RULE19: Optional active-high output shows override may be requested.
// RULE20: Muting output high: reset enables output; low: output follows override.
// RULE21: Manual reset takes a rising edge; monitored needs rise then fall.
// RULE22: Sequential muting activates on one then two, or four then three.
// RULE23: Times are counted in one millisecond ticks, cleared at interval start.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Millisecond interval counter, saturating so a stuck cycle never wraps
module mwo_timer
  import mwo_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_clr,
  input wire logic i_tick,
  output logic [31:0] o_cnt
);
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cnt <= 32'h0000_0000;
    end else if (i_clr) begin
      o_cnt <= 32'h0000_0000; // [RULE23]
    end else if (i_tick && o_cnt != CNT_MAX) begin
      o_cnt <= o_cnt + 32'h0000_0001;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module mwo_top
  import mwo_pkg::*;
#(
  parameter int P_TICK_CYC = TICK_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Field pins
  input wire logic i_sensor_one,
  input wire logic i_sensor_two,
  input wire logic i_sensor_three,
  input wire logic i_sensor_four,
  input wire logic i_curtain,
  input wire logic i_enable,
  input wire logic i_override_req,
  input wire logic i_reset_cmd,
  // Results
  output logic o_muting_out,
  output logic o_muting_active,
  output logic o_override_active_out,
  output logic o_override_request_ok,
  output logic o_safety_switching_output
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge history
  logic [7:0] meta_reg;
  logic [7:0] sync_reg;
  logic [7:0] prev_reg;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= 8'h10;
      sync_reg <= 8'h10;
      prev_reg <= 8'h10;
    end else begin
      meta_reg <= {i_reset_cmd, i_override_req, i_enable, i_curtain,
                   i_sensor_four, i_sensor_three, i_sensor_two, i_sensor_one};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  wire [3:0] sens = sync_reg[3:0];
  wire [3:0] sens_prev = prev_reg[3:0];
  wire curt = sync_reg[4];
  wire curt_rise = sync_reg[4] & ~prev_reg[4];
  wire en_rise = sync_reg[5] & ~prev_reg[5];
  wire en_fall = ~sync_reg[5] & prev_reg[5];
  wire orq = sync_reg[6];
  wire orq_rise = sync_reg[6] & ~prev_reg[6];
  wire rst_rise = sync_reg[7] & ~prev_reg[7];
  wire rst_fall = ~sync_reg[7] & prev_reg[7];

  //////////////////////////////////////////////////////////////////////////////
  // Registers and Wishbone slave; unmapped reads give zero, writes are dropped
  logic [31:0] cfg_reg;
  logic [31:0] tmo_reg;
  logic [31:0] win_reg;
  logic [31:0] stat_w;
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wb_wr = wb_req & i_wb_we;
  wire [31:0] wb_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire [31:0] rd_mux = (i_wb_adr == ADR_CFG) ? cfg_reg :
                       (i_wb_adr == ADR_TMO) ? tmo_reg :
                       (i_wb_adr == ADR_WIN) ? win_reg :
                       (i_wb_adr == ADR_STAT) ? stat_w : 32'h0000_0000;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_reg <= CFG_RST;
      tmo_reg <= TMO_RST;
      win_reg <= WIN_RST;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= wb_req ? rd_mux : 32'h0000_0000;
      if (wb_wr && i_wb_adr == ADR_CFG) begin
        cfg_reg <= ((cfg_reg & ~wb_mask) | (i_wb_dat & wb_mask)) & 32'h0000_07FF;
      end
      if (wb_wr && i_wb_adr == ADR_TMO) begin
        tmo_reg <= (tmo_reg & ~wb_mask) | (i_wb_dat & wb_mask);
      end
      if (wb_wr && i_wb_adr == ADR_WIN) begin
        win_reg <= (win_reg & ~wb_mask) | (i_wb_dat & wb_mask);
      end
    end
  end
  wire ttype = cfg_reg[CFG_TTYPE];
  wire en_used = cfg_reg[CFG_EN_USED];
  wire en_only = cfg_reg[CFG_EN_ONLY];
  wire [1:0] dir = cfg_reg[CFG_DIR_LO +: 2];
  wire close_sens = cfg_reg[CFG_CLOSE_SENS];
  wire blind_en = cfg_reg[CFG_BLIND_EN] & ~close_sens;
  wire ov_maint = cfg_reg[CFG_OV_MAINT];
  wire rst_mon = cfg_reg[CFG_RST_MON];
  // Timeout seconds become milliseconds here; a zero timeout keeps the interval unlimited
  wire [31:0] mute_lim = {16'h0000, tmo_reg[15:0]} * MS_PER_S;
  wire [31:0] ov_lim = {16'h0000, tmo_reg[31:16]} * MS_PER_S;
  wire [31:0] sens_lim = {16'h0000, win_reg[15:0]};
  wire [31:0] blind_lim = {16'h0000, win_reg[31:16]};

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and interval timers
  logic [31:0] div_reg;
  logic tick_reg;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == 32'(P_TICK_CYC - 1)); // [RULE23]
      div_reg <= (div_reg == 32'(P_TICK_CYC - 1)) ? 32'h0000_0000 : div_reg + 32'h0000_0001;
    end
  end
  mwo_mstate_t mst_reg;
  mwo_mstate_t mst_next;
  mwo_ostate_t ost_reg;
  mwo_ostate_t ost_next;
  logic [31:0] cyc_cnt;
  logic [31:0] win_cnt;
  logic [31:0] blind_cnt;
  logic [31:0] ov_cnt;
  mwo_timer u_cyc (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_clr(mst_reg == MS_IDLE), .i_tick(tick_reg), .o_cnt(cyc_cnt));
  mwo_timer u_win (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_clr(mst_reg != MS_FIRST), .i_tick(tick_reg), .o_cnt(win_cnt));
  mwo_timer u_blind (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_clr(mst_reg != MS_BLIND), .i_tick(tick_reg), .o_cnt(blind_cnt));
  mwo_timer u_ov (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_clr(ost_reg != OV_ACTIVE), .i_tick(tick_reg), .o_cnt(ov_cnt));

  //////////////////////////////////////////////////////////////////////////////
  // Muting sequence
  logic armed_reg;
  logic dir_down_reg;
  logic dir_down_next;
  wire arm_ok = ~en_used | armed_reg; // [RULE2]
  wire en_abort = en_used & ~en_only & en_fall; // [RULE4]
  wire pre_clear = (sens_prev == 4'h0) & prev_reg[4];
  wire may_start = arm_ok & pre_clear & curt; // [RULE11]
  wire up_start = (dir != DIR_DOWN) & (sens == 4'b0001); // [RULE6]
  wire dn_start = (dir != DIR_UP) & (sens == 4'b1000); // [RULE6]
  wire t_any = (sens[1:0] != 2'b00);
  wire first_s = dir_down_reg ? sens[3] : sens[0];
  wire second_s = dir_down_reg ? sens[2] : sens[1];
  wire third_fall = dir_down_reg ? (~sens[1] & sens_prev[1]) : (~sens[2] & sens_prev[2]);
  wire cyc_over = (tmo_reg[15:0] != 16'h0000) & (cyc_cnt >= mute_lim); // [RULE1]
  wire win_over = win_cnt > sens_lim; // [RULE12]
  wire blind_over = blind_cnt >= blind_lim;
  wire pair_on = ttype ? (sens[1:0] == 2'b11) : (first_s & second_s);
  wire pair_held = ttype ? t_any : first_s;

  always_comb begin
    mst_next = mst_reg;
    dir_down_next = dir_down_reg;
    unique case (mst_reg)
      MS_IDLE: begin
        if (may_start && ttype && t_any && sens[3:2] == 2'b00) begin
          mst_next = (sens[1:0] == 2'b11) ? MS_ACTIVE : MS_FIRST; // [RULE9]
          dir_down_next = 1'b0;
        end else if (may_start && !ttype && (up_start || dn_start)) begin
          mst_next = MS_FIRST; // [RULE22]
          dir_down_next = dn_start;
        end
      end
      MS_FIRST: begin
        if (win_over || !pair_held) begin
          mst_next = MS_IDLE; // [RULE12]
        end else if (pair_on) begin
          mst_next = MS_ACTIVE; // [RULE9] [RULE22]
        end
      end
      MS_ACTIVE: begin
        if (ttype && sens[1:0] != 2'b11) begin
          mst_next = MS_IDLE; // [RULE10]
        end else if (!ttype && close_sens && third_fall) begin
          mst_next = MS_IDLE; // [RULE7]
        end else if (!ttype && !close_sens && curt_rise) begin
          mst_next = (blind_en && blind_lim != 32'h0000_0000) ? MS_BLIND : MS_IDLE; // [RULE7]
        end
      end
      MS_BLIND: begin
        if (blind_over) begin
          mst_next = MS_IDLE; // [RULE8]
        end
      end
      default: mst_next = MS_IDLE;
    endcase
    if (mst_reg != MS_BLIND && cyc_over) begin
      mst_next = MS_IDLE; // [RULE1]
    end
    if (en_abort) begin
      mst_next = MS_IDLE; // [RULE4]
    end
  end

  wire starting = (mst_reg == MS_IDLE) && (mst_next != MS_IDLE);
  wire muted_next = (mst_next == MS_ACTIVE) || (mst_next == MS_BLIND); // [RULE8]
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      mst_reg <= MS_IDLE;
      dir_down_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      mst_reg <= mst_next;
      dir_down_reg <= dir_down_next;
      // An edge is consumed by the start so a level never opens two cycles
      armed_reg <= en_rise | (armed_reg & ~starting & ~en_abort); // [RULE3] [RULE5]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Override and block output
  logic mute_out_reg;
  logic rst_seen_reg;
  logic out_en_reg;
  wire occupied = (sens != 4'h0) | ~curt;
  wire ov_cond = ~mute_out_reg & occupied; // [RULE13]
  wire ov_tmo = (tmo_reg[31:16] != 16'h0000) & (ov_cnt >= ov_lim); // [RULE17]
  wire ov_stop = ~occupied | ov_tmo | (ov_maint & ~orq); // [RULE14] [RULE15]
  wire rst_evt = rst_mon ? (rst_fall & rst_seen_reg) : rst_rise; // [RULE21]

  always_comb begin
    ost_next = ost_reg;
    unique case (ost_reg)
      OV_IDLE: begin
        if (ov_cond && orq_rise) begin
          ost_next = OV_ACTIVE; // [RULE16]
        end
      end
      OV_ACTIVE: begin
        if (ov_stop) begin
          ost_next = OV_IDLE; // [RULE14]
        end
      end
      default: ost_next = OV_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ost_reg <= OV_IDLE;
      mute_out_reg <= 1'b0;
      rst_seen_reg <= 1'b0;
      out_en_reg <= 1'b0;
      o_muting_out <= 1'b0;
      o_muting_active <= 1'b0;
      o_override_active_out <= 1'b0;
      o_override_request_ok <= 1'b0;
      o_safety_switching_output <= 1'b0;
    end else begin
      ost_reg <= ost_next;
      mute_out_reg <= curt | muted_next;
      rst_seen_reg <= rst_rise | (rst_seen_reg & ~rst_fall);
      out_en_reg <= mute_out_reg & (out_en_reg | rst_evt); // [RULE20]
      o_muting_out <= mute_out_reg;
      o_muting_active <= (mst_reg == MS_ACTIVE);
      o_override_active_out <= cfg_reg[CFG_OVOUT_EN] & (ost_reg == OV_ACTIVE); // [RULE18]
      o_override_request_ok <= cfg_reg[CFG_REQ_EN] & (ost_reg == OV_IDLE) & ov_cond; // [RULE19]
      o_safety_switching_output <= (ost_reg == OV_ACTIVE) | (mute_out_reg & out_en_reg); // [RULE20]
    end
  end

  assign stat_w = {24'h00_0000, ost_reg, mst_reg, out_en_reg, mute_out_reg};

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_ov_start;
    ost_reg == OV_IDLE ##1 ost_reg == OV_ACTIVE;
  endsequence
  sequence s_mute_start;
    mst_reg == MS_IDLE ##1 mst_reg != MS_IDLE;
  endsequence

  a_cycle_timeout: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE1]
    (mst_reg == MS_ACTIVE && cyc_over) |=> mst_reg == MS_IDLE)
    else $error("muting cycle outlived its timeout");
  a_start_armed: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE3]
    s_mute_start |-> $past(arm_ok) && !armed_reg)
    else $error("muting started without an enable edge");
  a_enable_fall: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE4]
    (en_used && !en_only && en_fall) |=> mst_reg == MS_IDLE ##1 !o_muting_active)
    else $error("enable fall did not end muting");
  a_dir_up: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE6]
    (dir == DIR_UP && !ttype) throughout s_mute_start |-> !dir_down_reg)
    else $error("down travel accepted in up mode");
  a_t_release: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE10]
    (ttype && mst_reg == MS_ACTIVE && sens[1:0] != 2'b11) |=> mst_reg == MS_IDLE)
    else $error("t-type muting held after release");
  a_t_clear_start: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE11]
    s_mute_start |-> $past(curt) && $past(prev_reg[4]))
    else $error("muting started with curtain occupied");
  a_ov_only_unmuted: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE13]
    s_ov_start |-> $past(!mute_out_reg) && $past(orq_rise))
    else $error("override began while muted or without request edge");
  a_ov_clear_end: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE14]
    (ost_reg == OV_ACTIVE && !occupied) |=> ost_reg == OV_IDLE ##1 !o_override_active_out)
    else $error("override outlived clear opening");
  a_ov_maint_drop: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE15]
    (ost_reg == OV_ACTIVE && ov_maint && !orq) |=> ost_reg == OV_IDLE)
    else $error("maintained override kept without request");
  a_out_follows_ov: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE20]
    !mute_out_reg |=> o_safety_switching_output == $past(ost_reg == OV_ACTIVE))
    else $error("block output does not follow override while unmuted");
endmodule

//--- sim/mwo_field.sv
// Purpose: Field side model: muting sensors, curtain and operator commands
// Assumes: The bench hands over one packed command word per cycle
// Notes: Pins change only just after a clock edge, never mid-cycle
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module mwo_field (
  // Clock
  input wire logic i_clk_sys,
  // Command {one,two,three,four,curtain,enable,override,reset}
  input wire logic [7:0] i_cmd,
  // Field pins
  output logic o_sensor_one,
  output logic o_sensor_two,
  output logic o_sensor_three,
  output logic o_sensor_four,
  output logic o_curtain,
  output logic o_enable,
  output logic o_override_req,
  output logic o_reset_cmd
);
  // Curtain starts clear so the barrier is free at power up
  logic [7:0] pins_reg = 8'h08;

  // Operator keeps the override request up for as long as commanded
  always_ff @(posedge i_clk_sys) begin
    pins_reg <= i_cmd;
  end

  assign {o_sensor_one, o_sensor_two, o_sensor_three, o_sensor_four} = pins_reg[7:4];
  assign {o_curtain, o_enable, o_override_req, o_reset_cmd} = pins_reg[3:0];
endmodule

//--- sim/mwo_top_bench.sv
// Purpose: Self-checking bench for the muting with override block
// Assumes: Tick shortened to 4 cycles, so 1 ms is 32 ns
// Notes: Pin checks wait 10 cycles to cover sync and state latency
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module mwo_top_bench import mwo_pkg::*;;
  localparam int LIMIT = 30000;
  logic clk, rstn, cyc, stb, we, ack, pin_chk;
  logic [7:0] adr, cmd;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rnd;
  logic sen1, sen2, sen3, sen4, cur, en, req, rc;
  logic mout, mact, ovact, reqok, ssout;
  logic [31:0] reg_q[$];
  logic [9:0] pin_q[$];
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  integer seed = 32'h96ac_03c1;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  mwo_field field (.i_clk_sys(clk), .i_cmd(cmd), .o_sensor_one(sen1), .o_sensor_two(sen2),
    .o_sensor_three(sen3), .o_sensor_four(sen4), .o_curtain(cur), .o_enable(en),
    .o_override_req(req), .o_reset_cmd(rc));

  mwo_top #(.P_TICK_CYC(4)) dut (.i_clk_sys(clk), .i_resetn(rstn), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_sensor_one(sen1), .i_sensor_two(sen2),
    .i_sensor_three(sen3), .i_sensor_four(sen4), .i_curtain(cur), .i_enable(en),
    .i_override_req(req), .i_reset_cmd(rc), .o_muting_out(mout),
    .o_muting_active(mact), .o_override_active_out(ovact),
    .o_override_request_ok(reqok), .o_safety_switching_output(ssout));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("TB counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      $display("[ERR] %0t reg got %h exp %h", $time, g, e);
      fail_count++;
    end
  endtask

  task automatic cmp_pin(input logic [4:0] g, input logic [9:0] me);
    compares++;
    if ((g & me[9:5]) !== (me[4:0] & me[9:5])) begin
      $display("[ERR] %0t pins got %h exp %h mask %h", $time, g, me[4:0], me[9:5]);
      fail_count++;
    end
  endtask

  // Single classic cycle; waits for ack with no assumed latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] e);
    if (!w) reg_q.push_back(e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  // Set pins, let them settle, note expected {mout,mact,ovact,reqok,ssout}
  task automatic st(input logic [7:0] p, input logic [4:0] e, input logic [4:0] m);
    cmd <= p;
    repeat (10) @(posedge clk);
    pin_q.push_back({m, e});
    pin_chk <= 1'b1;
    @(posedge clk);
    pin_chk <= 1'b0;
  endtask

  task automatic done(input string n);
    $display("TB test %s done", n);
  endtask

  // Watcher: takes the oldest note whenever a result shows
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cyc && stb && ack && !we) cmp_reg(rdat, reg_q.pop_front());
    if (pin_chk) cmp_pin({mout, mact, ovact, reqok, ssout}, pin_q.pop_front());
    if (cycles == LIMIT) begin
      fail_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    {cyc, stb, we, pin_chk} = 4'h0;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    sel = 4'h0;
    cmd = 8'h08;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wb(0, ADR_CFG, '0, CFG_RST);
    wb(0, ADR_TMO, '0, TMO_RST);
    wb(0, ADR_WIN, '0, WIN_RST);
    wb(1, ADR_STAT, 32'hFFFF_FFFF, '0);
    wb(0, ADR_STAT, '0, 32'h0000_0045);
    rnd = $random(seed);
    wb(1, ADR_CFG, rnd, '0);
    wb(0, ADR_CFG, '0, rnd & 32'h0000_07FF);
    wb(0, {1'b1, rnd[6:2], 2'b00}, '0, '0);
    wb(1, ADR_CFG, '0, '0);
    done("wishbone");
    st(8'h09, 5'h11, 5'h11);
    st(8'h08, 5'h11, 5'h11);
    st(8'h00, 5'h00, 5'h11);
    st(8'h08, 5'h10, 5'h11);
    wb(1, ADR_CFG, 32'h0000_0100, '0);
    st(8'h09, 5'h10, 5'h11);
    st(8'h08, 5'h11, 5'h11);
    wb(1, ADR_CFG, '0, '0);
    done("reset");
    st(8'h88, 5'h10, 5'h18);
    st(8'hC8, 5'h18, 5'h18);
    st(8'hC0, 5'h18, 5'h18);
    st(8'h30, 5'h18, 5'h18);
    st(8'h38, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    done("sequential");
    wb(1, ADR_CFG, 32'h0000_0008, '0);
    st(8'h18, 5'h10, 5'h18);
    st(8'h38, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    st(8'h88, 5'h10, 5'h18);
    st(8'hC8, 5'h18, 5'h18);
    st(8'hC0, 5'h18, 5'h18);
    st(8'hC8, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    wb(1, ADR_CFG, 32'h0000_0010, '0);
    st(8'h88, 5'h10, 5'h18);
    st(8'hC8, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    st(8'h18, 5'h10, 5'h18);
    st(8'h38, 5'h18, 5'h18);
    st(8'h30, 5'h18, 5'h18);
    st(8'h38, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    done("direction");
    wb(1, ADR_CFG, 32'h0000_0020, '0);
    st(8'h88, 5'h10, 5'h18);
    st(8'hC8, 5'h18, 5'h18);
    st(8'hE0, 5'h18, 5'h18);
    st(8'h30, 5'h18, 5'h18);
    st(8'h38, 5'h18, 5'h18);
    st(8'h18, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    done("sensor close");
    wb(1, ADR_CFG, 32'h0000_0002, '0);
    st(8'h88, 5'h10, 5'h18);
    st(8'hC8, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    st(8'h0C, 5'h10, 5'h18);
    st(8'h8C, 5'h10, 5'h18);
    st(8'hCC, 5'h18, 5'h18);
    st(8'hC4, 5'h18, 5'h18);
    st(8'hCC, 5'h10, 5'h18);
    st(8'h0C, 5'h10, 5'h18);
    st(8'h8C, 5'h10, 5'h18);
    st(8'hCC, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    st(8'h0C, 5'h10, 5'h18);
    st(8'h8C, 5'h10, 5'h18);
    st(8'hCC, 5'h18, 5'h18);
    st(8'hC8, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    wb(1, ADR_CFG, 32'h0000_0006, '0);
    st(8'h0C, 5'h10, 5'h18);
    st(8'h8C, 5'h10, 5'h18);
    st(8'hCC, 5'h18, 5'h18);
    st(8'hC8, 5'h18, 5'h18);
    st(8'hC0, 5'h18, 5'h18);
    st(8'hC8, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    st(8'h88, 5'h10, 5'h18);
    st(8'hC8, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    done("enable");
    // Sensor time 5 ms, blind 50 ms: short enough to step over
    wb(1, ADR_WIN, 32'h0032_0005, '0);
    wb(1, ADR_CFG, 32'h0000_0001, '0);
    st(8'h48, 5'h10, 5'h18);
    st(8'hC8, 5'h18, 5'h18);
    st(8'h88, 5'h10, 5'h18);
    st(8'h00, 5'h00, 5'h18);
    st(8'h40, 5'h00, 5'h18);
    st(8'hC0, 5'h00, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    st(8'h88, 5'h10, 5'h18);
    repeat (40) @(posedge clk);
    st(8'hC8, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    done("t-type");
    wb(1, ADR_CFG, '0, '0);
    wb(1, ADR_TMO, 32'h000A_0001, '0);
    st(8'h88, 5'h10, 5'h18);
    st(8'hC8, 5'h18, 5'h18);
    repeat (4100) @(posedge clk);
    st(8'hC8, 5'h10, 5'h18);
    st(8'h08, 5'h10, 5'h18);
    done("timeout");
    wb(1, ADR_CFG, 32'h0000_0040, '0);
    st(8'h88, 5'h10, 5'h18);
    st(8'hC8, 5'h18, 5'h18);
    st(8'hC0, 5'h18, 5'h18);
    st(8'h30, 5'h18, 5'h18);
    st(8'h38, 5'h10, 5'h18);
    st(8'h30, 5'h10, 5'h10);
    repeat (250) @(posedge clk);
    st(8'h30, 5'h00, 5'h12);
    done("blind");
    wb(1, ADR_CFG, 32'h0000_0600, '0);
    st(8'h30, 5'h02, 5'h0E);
    st(8'h32, 5'h05, 5'h05);
    st(8'h30, 5'h05, 5'h05);
    st(8'h08, 5'h00, 5'h06);
    st(8'h0A, 5'h00, 5'h06);
    st(8'h30, 5'h00, 5'h04);
    wb(1, ADR_TMO, 32'h0001_0001, '0);
    wb(1, ADR_CFG, 32'h0000_0680, '0);
    st(8'h32, 5'h05, 5'h05);
    st(8'h30, 5'h00, 5'h05);
    // Status output switched off: override still drives the block output
    wb(1, ADR_CFG, 32'h0000_0480, '0);
    st(8'h32, 5'h01, 5'h05);
    repeat (4100) @(posedge clk);
    st(8'h32, 5'h00, 5'h05);
    st(8'h08, 5'h00, 5'h04);
    done("override");
    print_verdict();
  end
endmodule
